// ==== muxed_async_sram_port.v ====
`timescale 1ns/1ps
`default_nettype none
`include "muxed_port_defs.vh"
module muxed_async_sram_port (
	input  wire        sys_clk,
	input  wire        rst,
	input  wire        ce,
	input  wire [7:0]  awaddr,
	input  wire        awvalid,
	output wire        awready,
	input  wire [31:0] wdata,
	input  wire [3:0]  wstrb,
	input  wire        wvalid,
	output wire        wready,
	output reg  [1:0]  bresp,
	output reg         bvalid,
	input  wire        bready,
	input  wire [7:0]  araddr,
	input  wire        arvalid,
	output wire        arready,
	output reg  [31:0] rdata,
	output reg  [1:0]  rresp,
	output reg         rvalid,
	input  wire        rready,
	output reg         mem_req,
	output reg         mem_we,
	output reg  [18:0] mem_addr,
	output reg  [31:0] mem_wdata,
	input  wire [31:0] mem_rdata,
	input  wire        mem_ack,
	input  wire [15:0] ad_in,
	output reg  [15:0] ad_out,
	output reg  [15:0] ad_oe_n,
	output wire        rd_n,
	output wire        wr_n,
	output wire        ale
);

	localparam B_IDLE  = 2'b00;
	localparam B_LATCH = 2'b01;
	localparam B_DATA  = 2'b10;
	localparam B_HOLD  = 2'b11;
	localparam D_IDLE  = 2'b00;
	localparam D_FETCH = 2'b01;
	localparam D_STORE = 2'b10;
	localparam D_DESC  = 2'b11;

	// ****************************************
	// State
	// ****************************************
	reg [31:0] ctl;
	reg [15:0] icnt;
	reg [23:0] ecnt;
	reg [23:0] eaddr;
	reg [1:0]  step;
	reg [18:0] iidx;
	reg [18:0] chain;
	reg [31:0] rx_buf;
	reg [31:0] tx_buf;
	reg [31:0] sh;
	reg        rx_v;
	reg        tx_v;
	reg [2:0]  sh_cnt;
	reg [1:0]  bstate;
	reg [1:0]  dstate;
	reg [7:0]  bcnt;
	reg        need_latch;
	reg [15:0] last_hi;
	reg [2:0]  di;
	reg [15:0] ad_s1;
	reg [15:0] ad_s2;
	reg [31:0] rd_word;

	// ****************************************
	// Decode
	// ****************************************
	wire        en         = ctl[`CTL_EN];
	wire        dma_on     = en & ctl[`CTL_DMA];
	wire        dir        = ctl[`CTL_DIR];
	wire        wide       = ctl[`CTL_WIDE];
	wire        hold       = ctl[`CTL_HOLD];
	wire        chen       = ctl[`CTL_CHEN];
	wire        pol        = ctl[`CTL_ALE_POL];
	wire [4:0]  dur        = ctl[`CTL_DUR_HI:`CTL_DUR_LO];
	// A zero length would give no strobe at all, so it acts as one clock
	wire [7:0]  dur_last   = (dur == 5'h00) ? 8'h00 : ({3'h0, dur} - 8'h01);
	wire [2:0]  units      = wide ? 3'h2 : 3'h4;
	wire [23:0] amask      = wide ? `HALF_ADDR_MASK : `BYTE_ADDR_MASK;
	wire [23:0] next_eaddr = (eaddr + {{22{step[1]}}, step}) & amask;
	wire [15:0] latch_val  = wide ? eaddr[15:0] : eaddr[23:8];
	wire        want_latch = need_latch | (wide ? (step != 2'b00) : (latch_val != last_hi));
	wire        unit_ok    = dir ? (sh_cnt != 3'h0) : (sh_cnt != units);
	wire        can_go     = en & (ecnt != 24'h00_0000) & unit_ok;
	wire        data_end   = (bstate == B_DATA) & (bcnt == dur_last);
	wire        unit_done  = (data_end & ~hold) | (bstate == B_HOLD);
	wire        busy       = (bstate != B_IDLE);
	wire        dma_act    = dma_on & ((icnt != 16'h0000) | (ecnt != 24'h00_0000) | (dstate != D_IDLE));
	wire [31:0] wmask      = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
	wire [31:0] ctl_new    = (ctl & ~wmask) | (wdata & wmask);
	wire [31:0] status     = ctl | {12'h000, dma_act, rx_v, tx_v, busy, 16'h0000};
	wire        aw_bad     = (awaddr > `REG_CHAIN) | (awaddr[1:0] != 2'b00);
	wire        ar_bad     = (araddr > `REG_CHAIN) | (araddr[1:0] != 2'b00);
	wire        aw_tx      = (awaddr == `REG_TX);
	// Outside DMA, core writes to a full transmit buffer stall the bus instead of overwriting
	wire        wr_go      = ce & awvalid & wvalid & ~bvalid & ~(aw_tx & tx_v & en & ~dma_on);
	wire        rd_go      = ce & arvalid & ~rvalid;

	assign awready = wr_go;
	assign wready  = wr_go;
	assign arready = ce & ~rvalid;

	// ****************************************
	// Pins
	// ****************************************
	assign ale  = pol ^ ((bstate == B_LATCH) & (bcnt == 8'h01));
	assign rd_n = ~((bstate == B_DATA) & ~dir);
	assign wr_n = ~((bstate == B_DATA) & dir);

	always @* begin
		ad_out  = 16'h0000;
		ad_oe_n = 16'hFFFF;
		if (bstate == B_LATCH) begin
			ad_out  = latch_val;
			ad_oe_n = 16'h0000;
		end else if (bstate != B_IDLE) begin
			if (wide) begin
				ad_out  = sh[15:0];
				ad_oe_n = dir ? 16'h0000 : 16'hFFFF;
			end else begin
				ad_out  = {eaddr[7:0], sh[7:0]};
				ad_oe_n = {8'h00, dir ? 8'h00 : 8'hFF};
			end
		end
	end

	always @* begin
		case (araddr)
			`REG_CTL:   rd_word = status;
			`REG_RX:    rd_word = rx_buf;
			`REG_ICNT:  rd_word = {16'h0000, icnt};
			`REG_ECNT:  rd_word = {8'h00, ecnt};
			`REG_EADDR: rd_word = {8'h00, eaddr};
			`REG_STEP:  rd_word = {30'h0000_0000, step};
			`REG_IIDX:  rd_word = {13'h0000, iidx};
			`REG_CHAIN: rd_word = {13'h0000, chain};
			default:    rd_word = 32'h0000_0000;
		endcase
	end

	// ****************************************
	// Registers, bus engine and DMA
	// ****************************************
	always @(posedge sys_clk) begin
		if (rst) begin
			ctl        <= `CTL_RESET;
			icnt       <= 16'h0000;
			ecnt       <= 24'h00_0000;
			eaddr      <= 24'h00_0000;
			step       <= 2'b00;
			iidx       <= 19'h0_0000;
			chain      <= 19'h0_0000;
			rx_buf     <= 32'h0000_0000;
			tx_buf     <= 32'h0000_0000;
			sh         <= 32'h0000_0000;
			rx_v       <= 1'b0;
			tx_v       <= 1'b0;
			sh_cnt     <= 3'h0;
			bstate     <= B_IDLE;
			dstate     <= D_IDLE;
			bcnt       <= 8'h00;
			need_latch <= 1'b1;
			last_hi    <= 16'h0000;
			di         <= 3'h0;
			ad_s1      <= 16'h0000;
			ad_s2      <= 16'h0000;
			bresp      <= `RESP_OK;
			bvalid     <= 1'b0;
			rdata      <= 32'h0000_0000;
			rresp      <= `RESP_OK;
			rvalid     <= 1'b0;
			mem_req    <= 1'b0;
			mem_we     <= 1'b0;
			mem_addr   <= 19'h0_0000;
			mem_wdata  <= 32'h0000_0000;
		end else if (ce) begin
			ad_s1 <= ad_in;
			ad_s2 <= ad_s1;

			if (wr_go) begin
				bvalid <= 1'b1;
				bresp  <= aw_bad ? `RESP_ERR : `RESP_OK;
				case (awaddr)
					`REG_CTL: begin
						if (dma_act)
							ctl <= (ctl & ~`CTL_LIVE_MASK) | (ctl_new & `CTL_LIVE_MASK);
						else
							ctl <= ctl_new & `CTL_RW_MASK;
					end
					`REG_TX: begin
						if (!dma_on) begin
							tx_buf <= (tx_buf & ~wmask) | (wdata & wmask);
							tx_v   <= 1'b1;
						end
					end
					`REG_ICNT: begin
						if (!dma_act)
							icnt <= (icnt & ~wmask[15:0]) | (wdata[15:0] & wmask[15:0]);
					end
					`REG_ECNT: begin
						if (!dma_act)
							ecnt <= (ecnt & ~wmask[23:0]) | (wdata[23:0] & wmask[23:0]);
					end
					`REG_EADDR: begin
						if (!dma_act)
							eaddr <= (eaddr & ~wmask[23:0]) | (wdata[23:0] & wmask[23:0]);
					end
					`REG_STEP: begin
						if (!dma_act && wstrb[0])
							step <= wdata[1:0];
					end
					`REG_IIDX: begin
						if (!dma_act)
							iidx <= (iidx & ~wmask[18:0]) | (wdata[18:0] & wmask[18:0]);
					end
					`REG_CHAIN: begin
						if (!dma_act)
							chain <= (chain & ~wmask[18:0]) | (wdata[18:0] & wmask[18:0]);
					end
					default: begin
					end
				endcase
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end

			if (rd_go) begin
				rvalid <= 1'b1;
				rdata  <= rd_word;
				rresp  <= ar_bad ? `RESP_ERR : `RESP_OK;
				// Core reads during DMA see the buffer but must not steal it
				if ((araddr == `REG_RX) && rx_v && !dma_on)
					rx_v <= 1'b0;
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
			end

			// Word staging between buffers and the unit shifter
			if (dir && (sh_cnt == 3'h0) && tx_v) begin
				sh     <= tx_buf;
				sh_cnt <= units;
				tx_v   <= 1'b0;
			end
			if (!dir && (sh_cnt == units) && !rx_v) begin
				rx_buf <= sh;
				rx_v   <= 1'b1;
				sh_cnt <= 3'h0;
			end

			case (bstate)
				B_IDLE: begin
					if (can_go) begin
						bcnt   <= 8'h00;
						bstate <= want_latch ? B_LATCH : B_DATA;
					end
				end
				B_LATCH: begin
					if (bcnt == (`LATCH_CLKS - 8'h01)) begin
						last_hi    <= latch_val;
						need_latch <= 1'b0;
						bcnt       <= 8'h00;
						bstate     <= B_DATA;
					end else begin
						bcnt <= bcnt + 8'h01;
					end
				end
				B_DATA: begin
					if (data_end) begin
						bcnt   <= 8'h00;
						bstate <= hold ? B_HOLD : B_IDLE;
						// Pin data is two clocks old here; the strobe rises next clock
						if (!dir)
							sh <= wide ? {ad_s2, sh[31:16]} : {ad_s2[7:0], sh[31:8]};
					end else begin
						bcnt <= bcnt + 8'h01;
					end
				end
				B_HOLD: bstate <= B_IDLE;
				default: bstate <= B_IDLE;
			endcase

			if (unit_done) begin
				eaddr <= next_eaddr;
				ecnt  <= ecnt - 24'h00_0001;
				if (dir) begin
					sh     <= wide ? {16'h0000, sh[31:16]} : {8'h00, sh[31:8]};
					sh_cnt <= sh_cnt - 3'h1;
				end else begin
					sh_cnt <= sh_cnt + 3'h1;
				end
			end

			case (dstate)
				D_IDLE: begin
					if (dma_on) begin
						if (dir && (icnt != 16'h0000) && !tx_v) begin
							mem_req  <= 1'b1;
							mem_we   <= 1'b0;
							mem_addr <= iidx;
							dstate   <= D_FETCH;
						end else if (!dir && (icnt != 16'h0000) && rx_v) begin
							mem_req   <= 1'b1;
							mem_we    <= 1'b1;
							mem_addr  <= iidx;
							mem_wdata <= rx_buf;
							rx_v      <= 1'b0;
							dstate    <= D_STORE;
						end else if (chen && (icnt == 16'h0000) && (ecnt == 24'h00_0000) &&
							(chain != 19'h0_0000)) begin
							mem_req  <= 1'b1;
							mem_we   <= 1'b0;
							mem_addr <= chain;
							di       <= 3'h0;
							dstate   <= D_DESC;
						end
					end
				end
				D_FETCH: begin
					if (mem_ack) begin
						mem_req <= 1'b0;
						tx_buf  <= mem_rdata;
						tx_v    <= 1'b1;
						iidx    <= iidx + 19'h0_0001;
						icnt    <= icnt - 16'h0001;
						dstate  <= D_IDLE;
					end
				end
				D_STORE: begin
					if (mem_ack) begin
						mem_req <= 1'b0;
						iidx    <= iidx + 19'h0_0001;
						icnt    <= icnt - 16'h0001;
						dstate  <= D_IDLE;
					end
				end
				D_DESC: begin
					if (mem_ack) begin
						case (di)
							3'h0:    iidx  <= mem_rdata[18:0];
							3'h1:    icnt  <= mem_rdata[15:0];
							3'h2:    ecnt  <= mem_rdata[23:0];
							3'h3:    eaddr <= mem_rdata[23:0];
							default: chain <= mem_rdata[18:0];
						endcase
						di       <= di + 3'h1;
						mem_addr <= mem_addr + 19'h0_0001;
						if (di == `DESC_LAST) begin
							mem_req <= 1'b0;
							dstate  <= D_IDLE;
						end
					end
				end
				default: dstate <= D_IDLE;
			endcase

			// Disabling aborts any bus cycle; a half-packed word is lost too
			if (!en) begin
				rx_v       <= 1'b0;
				tx_v       <= 1'b0;
				sh_cnt     <= 3'h0;
				need_latch <= 1'b1;
				bstate     <= B_IDLE;
			end
		end
	end

endmodule
`default_nettype wire

// ==== muxed_port_defs.vh ====
`ifndef MUXED_PORT_DEFS_VH
`define MUXED_PORT_DEFS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define REG_CTL         8'h00
`define REG_RX          8'h04
`define REG_TX          8'h08
`define REG_ICNT        8'h0C
`define REG_ECNT        8'h10
`define REG_EADDR       8'h14
`define REG_STEP        8'h18
`define REG_IIDX        8'h1C
`define REG_CHAIN       8'h20

// ****************************************
// Control register fields
// ****************************************
`define CTL_EN          0
`define CTL_DMA         1
`define CTL_DIR         2
`define CTL_WIDE        3
`define CTL_DUR_LO      4
`define CTL_DUR_HI      8
`define CTL_HOLD        9
`define CTL_ALE_POL     13
`define CTL_BUSY        16
`define CTL_TXF         17
`define CTL_RXV         18
`define CTL_DACT        19
`define CTL_CHEN        30
`define CTL_RESET       32'h0000_0030
`define CTL_RW_MASK     32'h4000_23FF
`define CTL_LIVE_MASK   32'h0000_0003

// ****************************************
// Timing and layout
// ****************************************
`define CLK_PERIOD_NS   25
`define LATCH_CLKS      8'h03
`define BYTE_ADDR_MASK  24'hFF_FFFF
`define HALF_ADDR_MASK  24'h00_FFFF
`define DESC_LAST       3'h4
`define RESP_OK         2'h0
`define RESP_ERR        2'h2

`endif

// ==== muxed_port_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Bus and pin timing checks
// ****************************************
module muxed_port_chk (
	input wire        sys_clk,
	input wire        rst,
	input wire        awvalid,
	input wire        awready,
	input wire        wready,
	input wire        bvalid,
	input wire        bready,
	input wire [1:0]  bresp,
	input wire        arvalid,
	input wire        arready,
	input wire        rvalid,
	input wire        rready,
	input wire [31:0] rdata,
	input wire [15:0] ad_oe_n,
	input wire        rd_n,
	input wire        wr_n,
	input wire        ale
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	// Latch checks assume the default strobe polarity
	a_write_answer: assert property (awvalid && awready |=> bvalid) else $error("write response late");
	a_read_answer: assert property (arvalid && arready |=> rvalid) else $error("read response late");
	a_resp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("bresp moved");
	a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("rdata moved");
	a_ready_pair: assert property (awready == wready) else $error("write readies split");
	a_ale_window: assert property ($rose(ale) |-> ad_oe_n == 16'h0000 && $past(ad_oe_n) == 16'h0000
		##1 !ale && ad_oe_n == 16'h0000) else $error("latch strobe outside address");
	a_latch_quiet: assert property (ale |-> rd_n && wr_n) else $error("strobe during latch");
	a_write_drive: assert property (!wr_n |-> ad_oe_n == 16'h0000 && rd_n) else $error("write lines idle");
	a_read_lines: assert property (!rd_n |-> ad_oe_n[7:0] == 8'hFF) else $error("data lines driven on read");
endmodule
bind muxed_async_sram_port muxed_port_chk u_chk (.sys_clk, .rst, .awvalid, .awready, .wready, .bvalid,
	.bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata, .ad_oe_n, .rd_n, .wr_n, .ale);
`default_nettype wire

// ==== sram_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// External latch and byte memory
// ****************************************
module sram_model (
	input  wire        sys_clk,
	input  wire        wide,
	input  wire [15:0] ad_out,
	input  wire [15:0] ad_oe_n,
	input  wire        rd_n,
	input  wire        wr_n,
	input  wire        ale,
	output wire [15:0] ad_in
);
	reg  [7:0]  mem [0:255];
	reg  [15:0] hmem [0:15];
	reg  [15:0] latch = 16'h0000;
	reg  [15:0] last  = 16'h0000;
	// Halfword parts take their whole address from the latch, byte parts ignore it and take theirs from the upper lines
	wire [15:0] word  = wide ? hmem[latch[3:0]] : {~last[15:8], mem[ad_out[15:8]]};
	// Released lines toggle so a stale value never reads as good
	wire [15:0] far   = rd_n ? ~last : word;
	assign ad_in = (~ad_oe_n & ad_out) | (ad_oe_n & far);
	always @(posedge sys_clk) begin
		last <= ad_in;
		if (ale)
			latch <= ad_in;
		if (!wr_n && wide)
			hmem[latch[3:0]] <= ad_out;
		if (!wr_n && !wide)
			mem[ad_out[15:8]] <= ad_out[7:0];
	end
endmodule
`default_nettype wire

// ==== muxed_async_sram_port_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "muxed_port_defs.vh"
module muxed_async_sram_port_tb_top;
	reg         sys_clk = 1'h0;
	reg         rst     = 1'h1;
	reg  [7:0]  awaddr  = 8'h00;
	reg  [7:0]  araddr  = 8'h00;
	reg         awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0, mem_ack = 1'h0;
	reg  [31:0] wdata   = 32'h0000_0000;
	reg  [31:0] d;
	reg  [1:0]  r;
	reg         ale_q   = 1'h0;
	reg         hw      = 1'h0;
	reg  [31:0] imem [0:15];
	integer     miscompares = 0, check_count = 0, ale_n = 0, i;
	wire        awready, wready, bvalid, arready, rvalid, mem_req, mem_we, rd_n, wr_n, ale;
	wire [1:0]  bresp, rresp;
	wire [31:0] rdata, mem_wdata;
	wire [18:0] mem_addr;
	wire [31:0] mem_rdata = imem[mem_addr[3:0]];
	wire [15:0] ad_in, ad_out, ad_oe_n;
	always #12.5 sys_clk = ~sys_clk;
	// ****************************************
	// Internal memory responder and latch counter
	// ****************************************
	always @(posedge sys_clk) begin
		ale_q <= ale;
		if (ale && !ale_q)
			ale_n <= ale_n + 1;
		mem_ack <= mem_req && !mem_ack;
		if (mem_req && mem_we && !mem_ack)
			imem[mem_addr[3:0]] <= mem_wdata;
	end
	muxed_async_sram_port u_dut (.sys_clk, .rst, .ce(1'h1), .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF),
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack, .ad_in, .ad_out, .ad_oe_n,
		.rd_n, .wr_n, .ale);
	sram_model u_sram (.sys_clk, .wide(hw), .ad_out, .ad_oe_n, .rd_n, .wr_n, .ale, .ad_in);
	// ****************************************
	// Shared tasks
	// ****************************************
	task conclude;
		begin
			$display("checks %0d mismatches %0d", check_count, miscompares);
			if (miscompares == 0 && check_count > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	task hang;
		begin
			miscompares = miscompares + 1;
			conclude;
		end
	endtask
	task check(input [31:0] seen, input [31:0] exp, input string what);
		begin
			check_count = check_count + 1;
			if (seen !== exp) begin
				miscompares = miscompares + 1;
				$display("unexpected %s: expected %h seen %h", what, exp, seen);
			end
		end
	endtask
	task wr(input [7:0] a, input [31:0] v);
		integer n;
		begin
			awaddr <= a;
			wdata <= v;
			awvalid <= 1'h1;
			wvalid <= 1'h1;
			n = 0;
			do begin @(posedge sys_clk); n = n + 1; end while (!awready && n < 99);
			if (n == 99) hang;
			awvalid <= 1'h0;
			wvalid <= 1'h0;
			bready <= 1'h1;
			n = 0;
			do begin @(posedge sys_clk); n = n + 1; end while (!bvalid && n < 99);
			if (n == 99) hang;
			r = bresp;
			bready <= 1'h0;
		end
	endtask
	task rd(input [7:0] a);
		integer n;
		begin
			araddr <= a;
			arvalid <= 1'h1;
			n = 0;
			do begin @(posedge sys_clk); n = n + 1; end while (!arready && n < 99);
			if (n == 99) hang;
			arvalid <= 1'h0;
			rready <= 1'h1;
			n = 0;
			do begin @(posedge sys_clk); n = n + 1; end while (!rvalid && n < 99);
			if (n == 99) hang;
			d = rdata;
			r = rresp;
			rready <= 1'h0;
		end
	endtask
	task poll(input [7:0] a, input [31:0] m, input [31:0] v);
		integer k;
		begin
			k = 0;
			do begin rd(a); k = k + 1; end while ((d & m) !== v && k < 300);
			if (k == 300) hang;
		end
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task t_reset;
		begin
			rd(`REG_CTL);
			check(d, `CTL_RESET, "ctl reset");
			rd(8'h24);
			check(r, `RESP_ERR, "unmapped resp");
			wr(8'h24, 32'h0000_0000);
			check(r, `RESP_ERR, "unmapped write resp");
			$display("reset test done");
		end
	endtask
	task t_byte_write;
		begin
			wr(`REG_EADDR, 32'h0000_0100);
			wr(`REG_STEP, 32'h0000_0001);
			wr(`REG_ECNT, 32'h0000_0008);
			wr(`REG_CTL, 32'h0000_0035);
			wr(`REG_TX, 32'h4433_2211);
			wr(`REG_TX, 32'h8877_6655);
			// Busy drops between units, so only a spent count marks the end
			poll(`REG_ECNT, 32'h00FF_FFFF, 32'h0000_0000);
			check(u_sram.latch, 32'h0000_0001, "latched upper");
			check(ale_n, 32'h0000_0001, "latch count");
			for (i = 0; i < 8; i = i + 1)
				check(u_sram.mem[i], 8'h11 * (i + 1), "byte written");
			$display("byte write test done");
		end
	endtask
	task t_read_flush;
		begin
			wr(`REG_CTL, 32'h0000_0030);
			wr(`REG_EADDR, 32'h0000_0100);
			wr(`REG_ECNT, 32'h0000_0004);
			wr(`REG_CTL, 32'h0000_0031);
			poll(`REG_CTL, 32'h0004_0000, 32'h0004_0000);
			rd(`REG_RX);
			check(d, 32'h4433_2211, "rx word");
			check(ale_n, 32'h0000_0002, "latch after enable");
			wr(`REG_ECNT, 32'h0000_0004);
			poll(`REG_CTL, 32'h0004_0000, 32'h0004_0000);
			wr(`REG_CTL, 32'h0000_0030);
			rd(`REG_CTL);
			check(d & 32'h0006_0000, 32'h0000_0000, "flags after disable");
			$display("read flush test done");
		end
	endtask
	task t_dma;
		begin
			wr(`REG_IIDX, 32'h0000_0002);
			wr(`REG_ICNT, 32'h0000_0001);
			wr(`REG_ECNT, 32'h0000_0004);
			wr(`REG_EADDR, 32'h0000_0110);
			wr(`REG_CTL, 32'h0000_0037);
			wr(`REG_STEP, 32'h0000_0000);
			rd(`REG_STEP);
			check(d, 32'h0000_0001, "step during dma");
			poll(`REG_CTL, 32'h0009_0000, 32'h0000_0000);
			for (i = 0; i < 4; i = i + 1)
				check(u_sram.mem[16 + i], (32'hA5A5_5A5A >> (8 * i)) & 32'h0000_00FF, "dma byte");
			check(ale_n, 32'h0000_0003, "latch after dma enable");
			$display("dma test done");
		end
	endtask
	task t_half;
		begin
			wr(`REG_CTL, 32'h0000_0030);
			hw <= 1'h1;
			wr(`REG_EADDR, 32'h0000_0030);
			wr(`REG_ECNT, 32'h0000_0002);
			wr(`REG_CTL, 32'h0000_023D);
			wr(`REG_TX, 32'hBBBB_AAAA);
			poll(`REG_ECNT, 32'h00FF_FFFF, 32'h0000_0000);
			check(u_sram.hmem[0], 32'h0000_AAAA, "half first");
			check(u_sram.hmem[1], 32'h0000_BBBB, "half second");
			check(ale_n, 32'h0000_0005, "latch per half");
			wr(`REG_CTL, 32'h0000_0030);
			wr(`REG_EADDR, 32'h0000_0035);
			wr(`REG_STEP, 32'h0000_0000);
			wr(`REG_ECNT, 32'h0000_0002);
			wr(`REG_CTL, 32'h0000_023D);
			wr(`REG_TX, 32'hDDDD_CCCC);
			poll(`REG_ECNT, 32'h00FF_FFFF, 32'h0000_0000);
			check(u_sram.hmem[5], 32'h0000_DDDD, "half stream");
			check(ale_n, 32'h0000_0006, "single latch");
			rd(`REG_EADDR);
			check(d, 32'h0000_0035, "address held");
			wr(`REG_CTL, 32'h0000_0030);
			hw <= 1'h0;
			$display("halfword test done");
		end
	endtask
	task t_chain;
		begin
			wr(`REG_STEP, 32'h0000_0001);
			wr(`REG_ICNT, 32'h0000_0000);
			wr(`REG_ECNT, 32'h0000_0000);
			wr(`REG_CHAIN, 32'h0000_0008);
			wr(`REG_CTL, 32'h4000_0037);
			poll(`REG_CTL, 32'h0009_0000, 32'h0000_0000);
			for (i = 0; i < 4; i = i + 1)
				check(u_sram.mem[32 + i], (32'h1234_5678 >> (8 * i)) & 32'h0000_00FF, "chained byte");
			rd(`REG_IIDX);
			check(d, 32'h0000_0004, "descriptor index");
			rd(`REG_CHAIN);
			check(d, 32'h0000_0000, "chain end");
			check(ale_n, 32'h0000_0007, "latch after chain start");
			wr(`REG_CTL, 32'h0000_0030);
			$display("chain test done");
		end
	endtask
	initial begin
		imem[2] = 32'hA5A5_5A5A;
		imem[3] = 32'h1234_5678;
		// Descriptor: index, internal count, external count, address, next pointer
		imem[8] = 32'h0000_0003;
		imem[9] = 32'h0000_0001;
		imem[10] = 32'h0000_0004;
		imem[11] = 32'h0000_0120;
		imem[12] = 32'h0000_0000;
		repeat (10) @(posedge sys_clk);
		rst <= 1'h0;
		t_reset;
		t_byte_write;
		t_read_flush;
		t_dma;
		t_half;
		t_chain;
		conclude;
	end
endmodule
`default_nettype wire
